// [logic/sfc_cmd.v]
// serial flash decoder for latch, identification and register read commands
`timescale 1ns/1ps
`include "sfc_regs.vh"
module sfc_cmd #(
  parameter [7:0] MAKER_ID   = 8'h5a,  // arbitrary value
  parameter [7:0] MEM_TYPE   = 8'h11,  // arbitrary value
  parameter [7:0] DENSITY_ID = 8'h22,  // arbitrary value
  parameter [7:0] SIGNATURE  = 8'h33   // arbitrary value
) (
  input  wire       clk_in,
  input  wire       srst_in,
  input  wire       cs_n_in,
  input  wire       sclk_in,
  input  wire [3:0] sio_in,
  output wire [3:0] sio_out,
  output wire [3:0] sio_oe_n_out,
  input  wire       quad_mode_in,
  input  wire       hw_reset_n_in,
  input  wire       write_in_progress_in,
  input  wire [7:2] status_upper_in,
  input  wire [7:0] config_in,
  input  wire       wel_clear_done_in,
  input  wire       factory_clear_done_in,
  input  wire       suspend_req_in,
  output wire       suspend_accept_out,
  output reg        write_enable_latch_out,
  output reg        factory_mode_out
);
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_fall;
  wire       cs_rise;
  wire       tx_load;
  wire [3:0] tx_data;

  reg  [7:0] rx_shift_reg;
  reg  [7:0] cmd_reg;
  reg  [5:0] clk_cnt_reg;
  reg        addr_lsb_reg;
  reg  [1:0] idx_reg;
  reg        tx_en_reg;

  reg  [7:0] rx_full;
  reg  [5:0] cnt_next;
  reg  [5:0] cmd_len;
  reg  [7:0] cur_cmd;
  reg  [7:0] tx_byte;
  reg        latch_frame;

  function [5:0] lead_clks;
    input [7:0] cmd;
    begin
      case (cmd)
        `SFC_CMD_SIG:     lead_clks = `SFC_SIG_DUMMY_CLKS;
        `SFC_CMD_ADDR_ID: lead_clks = `SFC_ADDR_ID_CLKS;
        default:          lead_clks = 6'h00;
      endcase
    end
  endfunction

  function read_ok;
    input [7:0] cmd;
    input       quad;
    input       busy;
    begin
      case (cmd)
        `SFC_CMD_ID3:       read_ok = ~quad & ~busy;
        `SFC_CMD_ADDR_ID:   read_ok = ~quad;
        `SFC_CMD_QUAD_ID:   read_ok = quad;
        `SFC_CMD_SIG:       read_ok = 1'b1;
        `SFC_CMD_STATUS_RD: read_ok = 1'b1;
        `SFC_CMD_CONFIG_RD: read_ok = 1'b1;
        default:            read_ok = 1'b0;
      endcase
    end
  endfunction

  function [1:0] next_idx;
    input [7:0] cmd;
    input [1:0] idx;
    begin
      if (cmd == `SFC_CMD_ID3 || cmd == `SFC_CMD_QUAD_ID)
        next_idx = (idx == 2'h2) ? 2'h0 : idx + 2'h1;
      else
        next_idx = {1'b0, ~idx[0]};
    end
  endfunction

  sfc_pin_edge u_edge (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .cs_n_in       (cs_n_in),
    .sclk_in       (sclk_in),
    .sclk_rise_out (sclk_rise),
    .sclk_fall_out (sclk_fall),
    .cs_fall_out   (cs_fall),
    .cs_rise_out   (cs_rise)
  );

  sfc_tx_shift u_tx (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .clear_in (cs_fall),
    .quad_in  (quad_mode_in),
    .fall_in  (sclk_fall & tx_en_reg),
    .byte_in  (tx_byte),
    .load_out (tx_load),
    .data_out (tx_data)
  );

  always @* begin
    cmd_len = quad_mode_in ? `SFC_CMD_CLKS_QUAD : `SFC_CMD_CLKS_SINGLE;
    if (quad_mode_in)
      rx_full = {rx_shift_reg[3:0], sio_in};
    else
      rx_full = {rx_shift_reg[6:0], sio_in[0]};
    cnt_next = (clk_cnt_reg == `SFC_CNT_MAX) ? clk_cnt_reg : clk_cnt_reg + 6'h01;
    cur_cmd  = (cnt_next == cmd_len) ? rx_full : cmd_reg;
    // latch commands need exactly one code inside the frame
    latch_frame = cs_rise & (clk_cnt_reg == cmd_len);
    case (cmd_reg)
      `SFC_CMD_ID3,
      `SFC_CMD_QUAD_ID: begin
        case (idx_reg)
          2'h0:    tx_byte = MAKER_ID;
          2'h1:    tx_byte = MEM_TYPE;
          default: tx_byte = DENSITY_ID;
        endcase
      end
      `SFC_CMD_SIG:       tx_byte = SIGNATURE;
      `SFC_CMD_ADDR_ID:   tx_byte = (idx_reg[0] ^ addr_lsb_reg) ? DENSITY_ID : MAKER_ID;
      `SFC_CMD_STATUS_RD: tx_byte = {status_upper_in, write_enable_latch_out,
                                     write_in_progress_in};
      `SFC_CMD_CONFIG_RD: tx_byte = config_in;
      default:            tx_byte = 8'h00;
    endcase
  end

  always @(posedge clk_in) begin
    if (srst_in || cs_fall) begin
      rx_shift_reg <= 8'h00;
      cmd_reg      <= 8'h00;
      clk_cnt_reg  <= 6'h00;
      addr_lsb_reg <= 1'b0;
      idx_reg      <= 2'h0;
      tx_en_reg    <= 1'b0;
    end else if (cs_rise) begin
      tx_en_reg <= 1'b0;
    end else begin
      if (sclk_rise) begin
        rx_shift_reg <= rx_full;
        clk_cnt_reg  <= cnt_next;
        if (cnt_next == cmd_len)
          cmd_reg <= rx_full;
        // output starts on the falling edge after code and lead-in
        if (cnt_next == cmd_len + lead_clks(cur_cmd) && ~tx_en_reg &&
            read_ok(cur_cmd, quad_mode_in, write_in_progress_in)) begin
          tx_en_reg    <= 1'b1;
          addr_lsb_reg <= rx_full[0];
        end
      end
      if (tx_load)
        idx_reg <= next_idx(cmd_reg, idx_reg);
    end
  end

  always @(posedge clk_in) begin
    if (srst_in || ~hw_reset_n_in) begin
      write_enable_latch_out <= 1'b0;
      factory_mode_out       <= 1'b0;
    end else begin
      if (latch_frame && cmd_reg == `SFC_CMD_SET_WEL)
        write_enable_latch_out <= 1'b1;
      else if (latch_frame && cmd_reg == `SFC_CMD_CLR_WEL)
        write_enable_latch_out <= 1'b0;
      else if (wel_clear_done_in)
        write_enable_latch_out <= 1'b0;
      if (latch_frame && cmd_reg == `SFC_CMD_FACTORY && write_enable_latch_out)
        factory_mode_out <= 1'b1;
      else if (factory_clear_done_in)
        factory_mode_out <= 1'b0;
    end
  end

  assign suspend_accept_out = suspend_req_in & ~factory_mode_out;

  assign sio_out      = tx_en_reg ? tx_data : 4'h0;
  assign sio_oe_n_out = ~tx_en_reg   ? `SFC_OE_N_IDLE :
                        quad_mode_in ? `SFC_OE_N_QUAD : `SFC_OE_N_SINGLE;
endmodule

// [logic/sfc_regs.vh]
// command codes, frame lengths and pin masks of the simple-command decoder
`ifndef SFC_REGS_VH
`define SFC_REGS_VH

`define SFC_CMD_SET_WEL     8'h06
`define SFC_CMD_CLR_WEL     8'h04
`define SFC_CMD_FACTORY     8'h41
`define SFC_CMD_ID3         8'h9f
`define SFC_CMD_SIG         8'hab
`define SFC_CMD_ADDR_ID     8'h90
`define SFC_CMD_QUAD_ID     8'haf
`define SFC_CMD_STATUS_RD   8'h05
`define SFC_CMD_CONFIG_RD   8'h15

`define SFC_CMD_CLKS_SINGLE 6'h08
`define SFC_CMD_CLKS_QUAD   6'h02
`define SFC_SIG_DUMMY_CLKS  6'h18
`define SFC_ADDR_ID_CLKS    6'h18
`define SFC_CNT_MAX         6'h3f

`define SFC_OE_N_IDLE       4'hf
`define SFC_OE_N_SINGLE     4'hd
`define SFC_OE_N_QUAD       4'h0

`endif

// [logic/sfc_pin_edge.v]
// edge detection of serial clock and chip select pins
`timescale 1ns/1ps
module sfc_pin_edge (
  input  wire clk_in,
  input  wire srst_in,
  input  wire cs_n_in,
  input  wire sclk_in,
  output wire sclk_rise_out,
  output wire sclk_fall_out,
  output wire cs_fall_out,
  output wire cs_rise_out
);
  reg sclk_prev_reg;
  reg cs_n_prev_reg;

  always @(posedge clk_in) begin
    if (srst_in) begin
      sclk_prev_reg <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_in;
      cs_n_prev_reg <= cs_n_in;
    end
  end

  // clock edges only count inside a frame
  assign sclk_rise_out = ~cs_n_in & ~cs_n_prev_reg & sclk_in & ~sclk_prev_reg;
  assign sclk_fall_out = ~cs_n_in & ~cs_n_prev_reg & ~sclk_in & sclk_prev_reg;
  assign cs_fall_out   = ~cs_n_in & cs_n_prev_reg;
  assign cs_rise_out   = cs_n_in & ~cs_n_prev_reg;
endmodule

// [logic/sfc_tx_shift.v]
// msb-first output shifter, one bit or one nibble per falling clock edge
`timescale 1ns/1ps
module sfc_tx_shift (
  input  wire       clk_in,
  input  wire       srst_in,
  input  wire       clear_in,
  input  wire       quad_in,
  input  wire       fall_in,
  input  wire [7:0] byte_in,
  output wire       load_out,
  output reg  [3:0] data_out
);
  reg [7:0] shift_reg;
  reg [2:0] left_reg;

  assign load_out = fall_in & (left_reg == 3'h0);

  always @(posedge clk_in) begin
    if (srst_in || clear_in) begin
      shift_reg <= 8'h00;
      left_reg  <= 3'h0;
      data_out  <= 4'h0;
    end else if (fall_in) begin
      if (left_reg == 3'h0) begin
        if (quad_in) begin
          data_out  <= byte_in[7:4];
          shift_reg <= {byte_in[3:0], 4'h0};
          left_reg  <= 3'h1;
        end else begin
          data_out  <= {2'b00, byte_in[7], 1'b0};
          shift_reg <= {byte_in[6:0], 1'b0};
          left_reg  <= 3'h7;
        end
      end else begin
        if (quad_in) begin
          data_out  <= shift_reg[7:4];
          shift_reg <= {shift_reg[3:0], 4'h0};
        end else begin
          data_out  <= {2'b00, shift_reg[7], 1'b0};
          shift_reg <= {shift_reg[6:0], 1'b0};
        end
        left_reg <= left_reg - 3'h1;
      end
    end
  end
endmodule

// [tb/sfc_cmd_sva.sv]
// assertions on the decoder pins and flags
`timescale 1ns/1ps
module sfc_cmd_sva (
  input wire       clk_in,
  input wire       srst_in,
  input wire       cs_n_in,
  input wire       quad_mode_in,
  input wire       hw_reset_n_in,
  input wire       suspend_accept_out,
  input wire [3:0] sio_out,
  input wire [3:0] sio_oe_n_out,
  input wire       write_enable_latch_out,
  input wire       factory_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_suspend_refused:
    assert property (factory_mode_out |-> !suspend_accept_out) else $error("suspend taken");
  a_pin_clears_latch:
    assert property (!hw_reset_n_in |=> !write_enable_latch_out) else $error("latch kept");
  a_pin_clears_factory:
    assert property (!hw_reset_n_in |=> !factory_mode_out) else $error("factory kept");
  a_factory_needs_latch:
    assert property ($rose(factory_mode_out) |-> $past(write_enable_latch_out))
      else $error("factory without latch");
  a_latch_sets_idle:
    assert property ($rose(write_enable_latch_out) |-> cs_n_in) else $error("latch mid frame");
  a_idle_no_drive:
    assert property (cs_n_in [*4] |-> sio_oe_n_out == 4'hf) else $error("driving while idle");
  a_drive_follows_mode:
    assert property (sio_oe_n_out != 4'hf |-> sio_oe_n_out == (quad_mode_in ? 4'h0 : 4'hd))
      else $error("wrong enable set");
  a_single_one_line:
    assert property (sio_oe_n_out == 4'hd |-> (sio_out & 4'hd) == 4'h0) else $error("stray line");
endmodule
bind sfc_cmd sfc_cmd_sva i_sfc_cmd_sva (.*);

// [tb/sfc_host_model.sv]
// host controller model: select, serial clock and data lines
`timescale 1ns/1ps
module sfc_host_model (
  input  wire       clk_in,
  input  wire       quad_in,
  input  wire [3:0] sio_out,
  input  wire [3:0] oe_n_in,
  output reg        cs_n_out,
  output reg        sclk_out,
  output reg  [3:0] data_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    data_out = 4'h0;
  end
  task start;
    begin
      cs_n_out = 1'b0;
      repeat (2) @(negedge clk_in);
    end
  endtask
  task xfer(input [7:0] d, output [7:0] q);
    integer b;
    begin
      q = 8'h00;
      for (b = 0; b < (quad_in ? 2 : 8); b = b + 1) begin
        data_out = quad_in ? d[7:4] : {d[6:4], d[7]};
        d = quad_in ? {d[3:0], 4'h0} : {d[6:0], 1'b0};
        repeat (4) @(negedge clk_in);
        // undriven lines read back inverted, so a missing enable cannot pass
        q = quad_in ? {q[3:0], sio_out ^ oe_n_in} : {q[6:0], sio_out[1] ^ oe_n_in[1]};
        sclk_out = 1'b1;
        repeat (3) @(negedge clk_in);
        sclk_out = 1'b0;
      end
    end
  endtask
  task stop;
    begin
      repeat (2) @(negedge clk_in);
      cs_n_out = 1'b1;
      data_out = ~data_out;
      repeat (4) @(negedge clk_in);
    end
  endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for the simple-command decoder
`timescale 1ns/1ps
module testbench;
  localparam [7:0] MK = 8'h5a; // arbitrary value
  localparam [7:0] MT = 8'h11; // arbitrary value
  localparam [7:0] DN = 8'h22; // arbitrary value
  localparam [7:0] SG = 8'h33; // arbitrary value
  reg        clk_in = 1'b0;
  reg        srst_in = 1'b1;
  reg        quad = 1'b0;
  reg        hw_n = 1'b1;
  reg        write_in_progress = 1'b0;
  reg  [7:2] upper = 6'h00;
  reg  [7:0] cfg = 8'h00;
  reg        wel_done = 1'b0;
  reg        fm_done = 1'b0;
  reg        susp = 1'b0;
  reg  [7:0] adr;
  reg  [7:0] rd [0:3];
  reg  [7:0] ids [0:4] = '{8'h9f, 8'haf, 8'hab, 8'h90, 8'h90};
  wire       cs_n, sclk, susp_ok, write_enable_latch, fm;
  wire [3:0] sio_i, sio_o, oe_n;
  integer    seed = 32'hd173_61f2;
  integer    failures = 0;
  integer    checks_done = 0;
  integer    q, w, k, i, j, lead;
  always #2 clk_in = ~clk_in;
  sfc_cmd #(.MAKER_ID(MK), .MEM_TYPE(MT), .DENSITY_ID(DN), .SIGNATURE(SG)) i_sfc_cmd (
    .clk_in(clk_in), .srst_in(srst_in), .cs_n_in(cs_n), .sclk_in(sclk), .sio_in(sio_i),
    .sio_out(sio_o), .sio_oe_n_out(oe_n), .quad_mode_in(quad), .hw_reset_n_in(hw_n),
    .write_in_progress_in(write_in_progress), .status_upper_in(upper), .config_in(cfg),
    .wel_clear_done_in(wel_done), .factory_clear_done_in(fm_done), .suspend_req_in(susp),
    .suspend_accept_out(susp_ok), .write_enable_latch_out(write_enable_latch), .factory_mode_out(fm));
  sfc_host_model i_sfc_host_model (.clk_in(clk_in), .quad_in(quad), .sio_out(sio_o),
    .oe_n_in(oe_n), .cs_n_out(cs_n), .sclk_out(sclk), .data_out(sio_i));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task frame(input [7:0] c, input [7:0] a, input integer ld, input integer n);
    reg [7:0] x;
    begin
      i_sfc_host_model.start;
      i_sfc_host_model.xfer(c, x);
      repeat (ld) i_sfc_host_model.xfer(a, x);
      for (i = 0; i < n; i = i + 1)
        i_sfc_host_model.xfer(8'($random(seed)), rd[i]);
      i_sfc_host_model.stop;
    end
  endtask
  function [7:0] expect_id(input [7:0] c, input [7:0] a, input integer n);
    begin
      expect_id = 8'hff;
      if (c == 8'h9f && !quad && !write_in_progress || c == 8'haf && quad)
        expect_id = (n % 3 == 0) ? MK : (n % 3 == 1) ? MT : DN;
      else if (c == 8'hab)
        expect_id = SG;
      else if (c == 8'h90 && !quad)
        expect_id = ((n + a[0]) % 2) ? DN : MK;
    end
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #200_000;
    failures = failures + 1;
    complete_run;
  end
  initial begin
    repeat (5) @(negedge clk_in);
    srst_in = 1'b0;
    check(write_enable_latch, 1'b0);
    check(fm, 1'b0);
    for (q = 0; q < 2; q = q + 1) begin
      quad = q[0];
      frame(8'h06, 8'h00, 1, 0);
      check(write_enable_latch, 1'b0);
      frame(8'h41, 8'h00, 0, 0);
      check(fm, 1'b0);
      frame(8'h06, 8'h00, 0, 0);
      check(write_enable_latch, 1'b1);
      frame(8'h41, 8'h00, 0, 0);
      check(fm, 1'b1);
      susp = 1'b1;
      @(negedge clk_in);
      check(susp_ok, 1'b0);
      fm_done = 1'b1;
      @(negedge clk_in);
      fm_done = 1'b0;
      check(fm, 1'b0);
      check(susp_ok, 1'b1);
      susp = 1'b0;
      for (k = 0; k < 2; k = k + 1) begin
        upper = 6'($random(seed));
        write_in_progress = k[0];
        cfg = 8'($random(seed));
        frame(8'h05, 8'h00, 0, 2);
        check(rd[0], {upper, 1'b1, write_in_progress});
        check(rd[1], {upper, 1'b1, write_in_progress});
        check(rd[0][0], write_in_progress);
        frame(8'h15, 8'h00, 0, 2);
        check(rd[0], cfg);
        check(rd[1], cfg);
      end
      frame(8'h04, 8'h00, 0, 0);
      check(write_enable_latch, 1'b0);
      frame(8'h06, 8'h00, 0, 0);
      wel_done = 1'b1;
      @(negedge clk_in);
      wel_done = 1'b0;
      check(write_enable_latch, 1'b0);
      for (w = 0; w < 2; w = w + 1) begin
        write_in_progress = w[0];
        for (k = 0; k < 5; k = k + 1) begin
          adr = {7'h00, k == 4};
          lead = ids[k] == 8'hab ? 3 + 9 * q : (ids[k] == 8'h90 ? 3 : 0);
          frame(ids[k], adr, lead, 4);
          for (j = 0; j < 4; j = j + 1)
            check(rd[j], expect_id(ids[k], adr, j));
        end
      end
      $display("mode %0d test done", q);
    end
    frame(8'h06, 8'h00, 0, 0);
    frame(8'h41, 8'h00, 0, 0);
    check(write_enable_latch, 1'b1);
    check(fm, 1'b1);
    hw_n = 1'b0;
    @(negedge clk_in);
    hw_n = 1'b1;
    check(write_enable_latch, 1'b0);
    check(fm, 1'b0);
    $display("reset pin test done");
    complete_run;
  end
endmodule
